// [core/far_data_move_or_rotate_left.sv]
// Execution datapath for far memory move, OR and rotate-left instructions
// Notes on behaviour
// - Move to accumulator copies memory byte unchanged; flags untouched.
// - Move to memory writes accumulator into memory byte; flags untouched.
// - OR to accumulator: acc OR memory into accumulator; only zero flag changes.
// - OR to memory: acc OR memory back into memory; only zero flag changes.
// - Rotate left: bit 7 into bit 0, written to memory, no flags.
// - Rotate left to accumulator: same rotation into accumulator, memory kept, no flags.
// - Rotate through carry: old bit 7 to carry, old carry to bit 0, to memory.
// - Rotate through carry to accumulator: same, result to accumulator, memory kept.
// - Accumulator rotate variants never write memory.
// - Carry rotates insert the carry value held before execution into bit 0.
`timescale 1ns/1ps
`default_nettype none
`include "far_alu_cfg.svh"
module far_data_move_or_rotate_left
  import far_alu_pkg::*;
#(
  parameter int DATA_W = `FAR_DATA_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              exec_valid_i,
  input  wire logic [3:0]        exec_op_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  input  wire logic              acc_load_i,
  input  wire logic [DATA_W-1:0] acc_load_data_i,
  input  wire logic              carry_load_i,
  input  wire logic              carry_load_data_i,
  output logic [DATA_W-1:0]      mem_wdata_o,
  output logic                   mem_we_o,
  output logic [DATA_W-1:0]      accumulator_o,
  output logic                   carry_o,
  output logic                   zero_o,
  output logic                   done_o
);
  // The bound checker and the 8-bit reset constants assume a byte-wide datapath
  if (DATA_W != 8) begin : g_width_check
    $error("DATA_W must be 8");
  end

  // Instruction code port must match the instruction type
  if ($bits(far_op_type) != `FAR_OP_W) begin : g_op_check
    $error("Instruction code width mismatch");
  end

  far_op_type        op;
  logic [DATA_W-1:0] result;
  logic              acc_we;
  logic              mw_we;
  logic              carry_we;
  logic              carry_new;
  logic              zero_we;
  logic              result_is_zero;
  logic [DATA_W-1:0] bit_clear;

  logic [DATA_W-1:0] acc_reg,   acc_next;
  logic              carry_reg, carry_next;
  logic              zero_reg,  zero_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic              we_reg,    we_next;
  exec_state_type    state_reg, state_next;

  // Codes outside the instruction set run as no operation
  always_comb begin
    op = op_nop;
    if (exec_valid_i) begin
      case (exec_op_i)
        op_far_move_to_acc,
        op_far_move_to_mem,
        op_far_or_to_acc,
        op_far_or_to_mem,
        op_far_rotate_left,
        op_far_rotate_left_to_acc,
        op_far_rotate_left_carry,
        op_far_rotate_left_carry_to_acc: begin
          op = far_op_type'(exec_op_i);
        end
        default: begin
          op = op_nop;
        end
      endcase
    end
  end

  far_alu_compute #(
    .DATA_W (DATA_W)
  ) u_compute (
    .op_i       (op),
    .acc_i      (acc_reg),
    .mem_i      (mem_rdata_i),
    .carry_i    (carry_reg),
    .result_o   (result),
    .acc_we_o   (acc_we),
    .mem_we_o   (mw_we),
    .carry_we_o (carry_we),
    .carry_o    (carry_new),
    .zero_we_o  (zero_we)
  );

  // Accumulator: external load, overridden by an instruction result
  always_comb begin
    acc_next = acc_reg;
    if (acc_load_i) begin
      acc_next = acc_load_data_i;
    end
    if (acc_we) begin
      acc_next = result;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_reg <= `FAR_ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Carry: external load, overridden by a carry rotate
  always_comb begin
    carry_next = carry_reg;
    if (carry_load_i) begin
      carry_next = carry_load_data_i;
    end
    if (carry_we) begin
      carry_next = carry_new;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      carry_reg <= `FAR_CARRY_RESET;
    end else begin
      carry_reg <= carry_next;
    end
  end

  // Per-bit zero detect of the result
  for (genvar b = 0; b < DATA_W; b++) begin : g_zero_bit
    assign bit_clear[b] = ~result[b];
  end
  assign result_is_zero = &bit_clear;

  // Zero flag: only the OR instructions touch it
  always_comb begin
    zero_next = zero_reg;
    if (zero_we) begin
      zero_next = result_is_zero;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      zero_reg <= `FAR_ZERO_RESET;
    end else begin
      zero_reg <= zero_next;
    end
  end

  // Memory write data: held until the next memory-writing instruction
  always_comb begin
    wdata_next = wdata_reg;
    if (mw_we) begin
      wdata_next = result;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wdata_reg <= `FAR_WDATA_RESET;
    end else begin
      wdata_reg <= wdata_next;
    end
  end

  // Memory write strobe: one cycle per memory-writing instruction
  always_comb begin
    we_next = mw_we;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      we_reg <= `FAR_WE_RESET;
    end else begin
      we_reg <= we_next;
    end
  end

  // Execution state: busy in the cycle after each accepted instruction
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (exec_valid_i) begin
          state_next = st_busy;
        end
      end
      st_busy: begin
        if (!exec_valid_i) begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mem_wdata_o   = wdata_reg;
  assign mem_we_o      = we_reg;
  assign accumulator_o = acc_reg;
  assign carry_o       = carry_reg;
  assign zero_o        = zero_reg;
  assign done_o        = (state_reg == st_busy);
endmodule : far_data_move_or_rotate_left
`default_nettype wire

// [common/far_alu_cfg.svh]
// Constants for the far data move, OR and rotate-left datapath
`ifndef FAR_ALU_CFG_SVH
`define FAR_ALU_CFG_SVH
`define FAR_DATA_W      8
`define FAR_ACC_RESET   8'h00
`define FAR_CARRY_RESET 1'b0
`define FAR_ZERO_RESET  1'b0
`define FAR_OP_W        4
`define FAR_WDATA_RESET 8'h00
`define FAR_WE_RESET    1'b0
`endif

// [common/far_alu_pkg.sv]
// Types for the far data move, OR and rotate-left datapath
package far_alu_pkg;
  typedef enum logic [3:0] {
    op_nop                          = 4'h0,
    op_far_move_to_acc              = 4'h1,
    op_far_move_to_mem              = 4'h2,
    op_far_or_to_acc                = 4'h3,
    op_far_or_to_mem                = 4'h4,
    op_far_rotate_left              = 4'h5,
    op_far_rotate_left_to_acc       = 4'h6,
    op_far_rotate_left_carry        = 4'h7,
    op_far_rotate_left_carry_to_acc = 4'h8
  } far_op_type;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } exec_state_type;
endpackage : far_alu_pkg

// [core/far_alu_compute.sv]
// Combinational result and flag former for far memory instructions
`timescale 1ns/1ps
`default_nettype none
module far_alu_compute
  import far_alu_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire far_op_type        op_i,
  input  wire logic [DATA_W-1:0] acc_i,
  input  wire logic [DATA_W-1:0] mem_i,
  input  wire logic              carry_i,
  output logic      [DATA_W-1:0] result_o,
  output logic                   acc_we_o,
  output logic                   mem_we_o,
  output logic                   carry_we_o,
  output logic                   carry_o,
  output logic                   zero_we_o
);
  if (DATA_W < 2) begin : g_width_check
    $error("DATA_W must be at least 2");
  end
  always_comb begin
    result_o   = mem_i;
    acc_we_o   = 1'b0;
    mem_we_o   = 1'b0;
    carry_we_o = 1'b0;
    zero_we_o  = 1'b0;
    carry_o    = carry_i;
    case (op_i)
      op_far_move_to_acc: begin
        result_o = mem_i;
        acc_we_o = 1'b1;
      end
      op_far_move_to_mem: begin
        result_o = acc_i;
        mem_we_o = 1'b1;
      end
      op_far_or_to_acc: begin
        result_o  = acc_i | mem_i;
        acc_we_o  = 1'b1;
        zero_we_o = 1'b1;
      end
      op_far_or_to_mem: begin
        result_o  = acc_i | mem_i;
        mem_we_o  = 1'b1;
        zero_we_o = 1'b1;
      end
      op_far_rotate_left: begin
        result_o = {mem_i[DATA_W-2:0], mem_i[DATA_W-1]};
        mem_we_o = 1'b1;
      end
      op_far_rotate_left_to_acc: begin
        result_o = {mem_i[DATA_W-2:0], mem_i[DATA_W-1]};
        acc_we_o = 1'b1;
      end
      op_far_rotate_left_carry: begin
        result_o   = {mem_i[DATA_W-2:0], carry_i};
        carry_o    = mem_i[DATA_W-1];
        carry_we_o = 1'b1;
        mem_we_o   = 1'b1;
      end
      op_far_rotate_left_carry_to_acc: begin
        result_o   = {mem_i[DATA_W-2:0], carry_i};
        carry_o    = mem_i[DATA_W-1];
        carry_we_o = 1'b1;
        acc_we_o   = 1'b1;
      end
      default: begin
        result_o = mem_i;
      end
    endcase
  end
endmodule : far_alu_compute
`default_nettype wire

// [dv/far_mem_model.sv]
// Data memory byte model feeding the datapath
`timescale 1ns/1ps
`default_nettype none
module far_mem_model (
  input  wire logic       ref_clk_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem_reg;
  always_ff @(posedge ref_clk_i) begin
    if (we_i) mem_reg <= wdata_i;
    else if (load_i) mem_reg <= load_data_i;
  end
  assign rdata_o = mem_reg;
endmodule : far_mem_model
`default_nettype wire

// [dv/far_data_move_or_rotate_left_assertions.sv]
// Assertions on the datapath ports
`timescale 1ns/1ps
`default_nettype none
module far_dmrl_checker (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       exec_valid_i,
  input wire logic [3:0] exec_op_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [7:0] mem_wdata_o,
  input wire logic       mem_we_o,
  input wire logic [7:0] accumulator_o,
  input wire logic       carry_o,
  input wire logic       zero_o
);
  logic [3:0] op;
  logic [7:0] m_reg, a_reg;
  logic       c_reg;
  assign op = exec_valid_i ? exec_op_i : 4'h0;
  always_ff @(posedge ref_clk_i) begin
    m_reg <= mem_rdata_i;
    a_reg <= accumulator_o;
    c_reg <= carry_o;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_mv; op == 4'h1 |=> accumulator_o == m_reg && zero_o == $past(zero_o); endproperty
  a_mv: assert property (p_mv) else $error("bad move");
  property p_st; op == 4'h2 |=> mem_we_o && mem_wdata_o == a_reg; endproperty
  a_st: assert property (p_st) else $error("bad store");
  property p_oa; op == 4'h3 |=> accumulator_o == (a_reg | m_reg) && zero_o == !accumulator_o; endproperty
  a_oa: assert property (p_oa) else $error("bad or acc");
  property p_om; op == 4'h4 |=> mem_we_o && mem_wdata_o == (a_reg | m_reg) && zero_o == !mem_wdata_o; endproperty
  a_om: assert property (p_om) else $error("bad or mem");
  property p_rl; op == 4'h5 |=> mem_we_o && mem_wdata_o == {m_reg[6:0], m_reg[7]}; endproperty
  a_rl: assert property (p_rl) else $error("bad rotate");
  property p_ra; op == 4'h6 |=> !mem_we_o && accumulator_o == {m_reg[6:0], m_reg[7]}; endproperty
  a_ra: assert property (p_ra) else $error("bad rotate acc");
  property p_rc; op == 4'h7 |=> mem_we_o && {carry_o, mem_wdata_o} == {m_reg, c_reg}; endproperty
  a_rc: assert property (p_rc) else $error("bad carry rotate");
  property p_rca; op == 4'h8 |=> !mem_we_o && {carry_o, accumulator_o} == {m_reg, c_reg}; endproperty
  a_rca: assert property (p_rca) else $error("bad carry rotate acc");
endmodule : far_dmrl_checker
bind far_data_move_or_rotate_left far_dmrl_checker u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .exec_valid_i(exec_valid_i), .exec_op_i(exec_op_i), .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o),
  .mem_we_o(mem_we_o), .accumulator_o(accumulator_o), .carry_o(carry_o), .zero_o(zero_o));
`default_nettype wire

// [dv/far_data_move_or_rotate_left_tb_top.sv]
// Testbench for the far move, OR and rotate-left datapath
`timescale 1ns/1ps
`default_nettype none
module far_data_move_or_rotate_left_tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       vld = 1'b0;
  logic [3:0] op = 4'h0;
  logic       ld = 1'b0;
  logic [7:0] ldd = 8'h00;
  logic       al = 1'b0;
  logic [7:0] ald = 8'h00;
  logic       cl = 1'b0;
  logic       cld = 1'b0;
  logic [7:0] rd, wd, acc;
  logic       we, cy, zr, dn;
  int         error_cnt = 0;
  int         num_checks = 0;
  initial forever #20 clk = ~clk;
  far_data_move_or_rotate_left u_dut (.ref_clk_i(clk), .reset_i(rst), .exec_valid_i(vld), .exec_op_i(op),
    .mem_rdata_i(rd), .acc_load_i(al), .acc_load_data_i(ald), .carry_load_i(cl),
    .carry_load_data_i(cld), .mem_wdata_o(wd), .mem_we_o(we), .accumulator_o(acc), .carry_o(cy),
    .zero_o(zr), .done_o(dn));
  far_mem_model u_mem (.ref_clk_i(clk), .we_i(we), .wdata_i(wd), .load_i(ld), .load_data_i(ldd), .rdata_o(rd));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [3:0] code, input logic [7:0] m);
    @(negedge clk);
    ld = 1'b1;
    ldd = m;
    @(negedge clk);
    ld = 1'b0;
    vld = 1'b1;
    op = code;
    @(negedge clk);
    vld = 1'b0;
    chk({8'h00, dn}, 9'h001);
  endtask : run
  task automatic t_rot;
    run(4'h5, 8'h81);
    chk({we, wd}, 9'h103);
    run(4'h6, 8'h40);
    chk({we, acc}, 9'h080);
    run(4'h7, 8'h81);
    chk({cy, wd}, 9'h102);
    run(4'h8, 8'h00);
    chk({cy, acc}, 9'h001);
    chk({8'h00, we}, 9'h000);
    $display("test rotate end");
  endtask : t_rot
  task automatic t_move;
    run(4'h1, 8'ha5);
    chk({zr, acc}, 9'h0a5);
    run(4'h2, 8'h00);
    chk({we, wd}, 9'h1a5);
    $display("test move end");
  endtask : t_move
  task automatic t_or;
    run(4'h1, 8'h00);
    run(4'h3, 8'h00);
    chk({zr, acc}, 9'h100);
    run(4'h1, 8'h0c);
    chk({zr, acc}, 9'h10c);
    run(4'h4, 8'h30);
    chk({zr, wd}, 9'h03c);
    $display("test or end");
  endtask : t_or
  task automatic t_keep;
    run(4'h1, 8'h00);
    run(4'h3, 8'h00);
    run(4'h7, 8'h80);
    chk({cy, wd}, 9'h100);
    chk({7'h00, zr, cy}, 9'h003);
    run(4'h5, 8'h81);
    chk({7'h00, zr, cy}, 9'h003);
    run(4'h6, 8'h01);
    chk({zr, acc}, 9'h102);
    chk({7'h00, we, cy}, 9'h001);
    run(4'h0, 8'hff);
    run(4'h9, 8'hff);
    chk({we, acc}, 9'h002);
    chk({7'h00, zr, cy}, 9'h003);
    run(4'h1, 8'h80);
    chk({7'h00, zr, cy}, 9'h003);
    run(4'h2, 8'h00);
    chk({we, wd}, 9'h180);
    chk({7'h00, zr, cy}, 9'h003);
    run(4'h7, 8'h00);
    chk({cy, wd}, 9'h001);
    $display("test keep end");
  endtask : t_keep
  task automatic t_load;
    @(negedge clk);
    al = 1'b1;
    ald = 8'h5a;
    cl = 1'b1;
    cld = 1'b1;
    ld = 1'b1;
    ldd = 8'h11;
    @(negedge clk);
    chk({cy, acc}, 9'h15a);
    ald = 8'hee;
    ld = 1'b0;
    vld = 1'b1;
    op = 4'h8;
    @(negedge clk);
    al = 1'b0;
    cl = 1'b0;
    vld = 1'b0;
    chk({cy, acc}, 9'h023);
    chk({8'h00, dn}, 9'h001);
    $display("test load end");
  endtask : t_load
  task automatic t_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk({we, wd}, 9'h000);
    chk({cy, acc}, 9'h000);
    chk({7'h00, zr, dn}, 9'h000);
    rst = 1'b0;
    run(4'h1, 8'h3c);
    chk({zr, acc}, 9'h03c);
    $display("test reset end");
  endtask : t_reset
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_rot();
    t_move();
    t_or();
    t_keep();
    t_load();
    t_reset();
    give_verdict();
  end
endmodule : far_data_move_or_rotate_left_tb_top
`default_nettype wire
